// File: design/dmbu_exec.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dmbu_exec
  import dmbu_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PM_AW = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire dmbu_op_t instr_op,
  input wire logic [4:0] instr_reg,
  input wire logic [2:0] instr_bit,
  input wire dmbu_ptr_t instr_ptr,
  input wire dmbu_mode_t instr_mode,
  input wire logic [DMBU_DISP_W-1:0] instr_disp,
  input wire logic [ADDR_W-1:0] instr_addr,
  output logic instr_ready,
  output logic instr_done,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  output logic [PM_AW-1:0] pm_addr,
  output logic pm_re,
  input wire logic [15:0] pm_rdata,
  output logic [5:0] io_addr,
  output logic io_re,
  output logic io_we,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  output logic [7:0] flags_out,
  output logic [7:0] stack_ptr_out
);

  logic [7:0] rf_reg [DMBU_NREG];
  logic [7:0] flags_reg, sp_reg, pm_byte_reg;
  dmbu_state_t state_reg, state_next;
  dmbu_op_t op_reg;
  logic [4:0] reg_sel_reg;
  logic [2:0] bit_sel_reg;
  logic pm_high_reg;
  logic accept, issue_rd, issue_wr, issue_io, rf_we, ptr_we, rot_carry, done_next;
  logic [4:0] ptr_lo, rf_wa;
  logic [15:0] ptr_val, eff_addr, ptr_wd;
  logic [ADDR_W-1:0] issue_addr;
  logic [7:0] rf_wd, flags_next, sp_next, rot_res, src_val;
  logic apb_acc, apb_wr, apb_hit_rf;

  assign accept = instr_valid && instr_ready && (state_reg == ST_IDLE);
  assign src_val = rf_reg[instr_reg];

  // Fixed pointer pairs, low register carries the low byte.
  // pointer pair select
  always_comb begin
    case (instr_ptr)
      PTR_X: ptr_lo = DMBU_X_LO;
      PTR_Y: ptr_lo = DMBU_Y_LO;
      default: ptr_lo = DMBU_Z_LO;
    endcase
    ptr_val = {rf_reg[{ptr_lo[4:1], 1'b1}], rf_reg[ptr_lo]};
  end

  always_comb begin
    case (instr_mode)
      MODE_PRE_DEC: eff_addr = ptr_val - 16'h0001;
      MODE_DISP: eff_addr = ptr_val + {10'h000, instr_disp};
      default: eff_addr = ptr_val;
    endcase
  end

  always_comb begin
    if (instr_op == OP_ROTATE_LEFT) begin
      rot_res = {src_val[6:0], flags_reg[DMBU_FLAG_C]};
      rot_carry = src_val[7];
    end else begin
      rot_res = {flags_reg[DMBU_FLAG_C], src_val[7:1]};
      rot_carry = src_val[0];
    end
  end

  always_comb begin
    issue_rd = 1'b0;
    issue_wr = 1'b0;
    issue_io = 1'b0;
    issue_addr = eff_addr[ADDR_W-1:0];
    rf_we = 1'b0;
    rf_wa = instr_reg;
    rf_wd = 8'h00;
    ptr_we = 1'b0;
    ptr_wd = ptr_val;
    flags_next = flags_reg;
    sp_next = sp_reg;
    state_next = state_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          done_next = 1'b1;
          case (instr_op)
            OP_LOAD_IND, OP_STORE_IND: begin
              issue_rd = (instr_op == OP_LOAD_IND);
              issue_wr = (instr_op == OP_STORE_IND);
              state_next = ST_MEM;
              done_next = 1'b0;
              if (instr_mode == MODE_POST_INC) begin
                ptr_we = 1'b1;
                ptr_wd = ptr_val + 16'h0001;
              end
              if (instr_mode == MODE_PRE_DEC) begin
                ptr_we = 1'b1;
                ptr_wd = eff_addr;
              end
            end
            OP_LOAD_ABS, OP_STORE_ABS: begin
              issue_rd = (instr_op == OP_LOAD_ABS);
              issue_wr = (instr_op == OP_STORE_ABS);
              issue_addr = instr_addr;
              state_next = ST_MEM;
              done_next = 1'b0;
            end
            OP_STACK_PUSH: begin
              issue_wr = 1'b1;
              issue_addr = ADDR_W'({DMBU_STACK_PAGE, sp_reg});
              sp_next = sp_reg - 8'h01;
              state_next = ST_MEM;
              done_next = 1'b0;
            end
            OP_STACK_POP: begin
              issue_rd = 1'b1;
              sp_next = sp_reg + 8'h01;
              issue_addr = ADDR_W'({DMBU_STACK_PAGE, sp_next});
              state_next = ST_MEM;
              done_next = 1'b0;
            end
            OP_PM_FETCH: begin
              state_next = ST_PM_ISSUE;
              done_next = 1'b0;
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              if (instr_addr[5:0] <= DMBU_IO_BIT_LIMIT && instr_addr[ADDR_W-1:6] == '0) begin
                issue_io = 1'b1;
                state_next = ST_MEM;
                done_next = 1'b0;
              end
            end
            OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
              rf_we = 1'b1;
              rf_wd = rot_res;
              flags_next[DMBU_FLAG_C] = rot_carry;
              flags_next[DMBU_FLAG_Z] = (rot_res == 8'h00);
              flags_next[DMBU_FLAG_N] = rot_res[7];
              flags_next[DMBU_FLAG_V] = rot_res[7] ^ rot_carry;
            end
            OP_FLAG_CAPTURE: flags_next[DMBU_FLAG_T] = src_val[instr_bit];
            OP_FLAG_DEPOSIT: begin
              rf_we = 1'b1;
              rf_wd = src_val;
              rf_wd[instr_bit] = flags_reg[DMBU_FLAG_T];
            end
            OP_FLAG_RAISE: flags_next[instr_bit] = 1'b1;
            OP_FLAG_LOWER: flags_next[instr_bit] = 1'b0;
            default: done_next = 1'b1;
          endcase
        end
      end
      ST_MEM: begin
        state_next = ST_IDLE;
        done_next = 1'b1;
        rf_wa = reg_sel_reg;
        rf_wd = mem_rdata;
        rf_we = (op_reg == OP_LOAD_IND) || (op_reg == OP_LOAD_ABS) ||
                (op_reg == OP_STACK_POP);
      end
      ST_PM_ISSUE: state_next = ST_PM_WRITE;
      default: begin
        state_next = ST_IDLE;
        done_next = 1'b1;
        rf_we = 1'b1;
        rf_wa = DMBU_R0;
        rf_wd = pm_byte_reg;
      end
    endcase
  end

  assign apb_acc = psel && penable && pready;
  assign apb_wr = apb_acc && pwrite && pstrb[0];
  assign apb_hit_rf = (paddr >= DMBU_OFS_REGFILE) && (paddr <= DMBU_OFS_REGFILE_END);

  // Software writes land after the core's own update, so they win a same-cycle clash.
  // pointer written back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DMBU_NREG; i++) begin
        rf_reg[i] <= 8'h00;
      end
    end else begin
      if (rf_we) begin
        rf_reg[rf_wa] <= rf_wd;
      end
      if (ptr_we) begin
        rf_reg[ptr_lo] <= ptr_wd[7:0];
        rf_reg[{ptr_lo[4:1], 1'b1}] <= ptr_wd[15:8];
      end
      if (apb_wr && apb_hit_rf) begin
        rf_reg[paddr[6:2]] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= DMBU_FLAGS_RST;
      flags_out <= DMBU_FLAGS_RST;
    end else if (apb_wr && paddr == DMBU_OFS_FLAGS) begin
      flags_reg <= pwdata[7:0];
      flags_out <= pwdata[7:0];
    end else begin
      flags_reg <= flags_next;
      flags_out <= flags_next;
    end
  end

  // The output copies follow the same priority, so a software write shows at once.
  // software stack pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= DMBU_SP_RST;
      stack_ptr_out <= DMBU_SP_RST;
    end else if (apb_wr && paddr == DMBU_OFS_STACK) begin
      sp_reg <= pwdata[7:0];
      stack_ptr_out <= pwdata[7:0];
    end else begin
      sp_reg <= sp_next;
      stack_ptr_out <= sp_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      instr_ready <= 1'b0;
      instr_done <= 1'b0;
      op_reg <= OP_NOP;
      reg_sel_reg <= 5'h00;
      bit_sel_reg <= 3'h0;
      pm_high_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      instr_ready <= (state_next == ST_IDLE);
      instr_done <= done_next;
      if (accept) begin
        op_reg <= instr_op;
        reg_sel_reg <= instr_reg;
        bit_sel_reg <= instr_bit;
        pm_high_reg <= rf_reg[DMBU_Z_LO][0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= '0;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
    end else begin
      mem_we <= issue_wr;
      mem_re <= issue_rd;
      if (issue_wr || issue_rd) begin
        mem_addr <= issue_addr;
        mem_wdata <= src_val;
      end
    end
  end

  // Program memory is word wide; the pointer's low bit picks the byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_addr <= '0;
      pm_re <= 1'b0;
      pm_byte_reg <= 8'h00;
    end else begin
      pm_re <= accept && (instr_op == OP_PM_FETCH);
      if (accept && instr_op == OP_PM_FETCH) begin
        pm_addr <= PM_AW'({rf_reg[DMBU_Z_LO + 5'h01], rf_reg[DMBU_Z_LO]} >> 1);
      end
      if (state_reg == ST_PM_ISSUE) begin
        pm_byte_reg <= pm_high_reg ? pm_rdata[15:8] : pm_rdata[7:0];
      end
    end
  end

  // The whole byte goes back, so write-one-to-clear flags read as set get cleared.
  // set or clear chosen bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_addr <= 6'h00;
      io_re <= 1'b0;
      io_we <= 1'b0;
      io_wdata <= 8'h00;
    end else begin
      io_re <= issue_io;
      io_we <= 1'b0;
      if (issue_io) begin
        io_addr <= instr_addr[5:0];
      end
      if (state_reg == ST_MEM && (op_reg == OP_IO_BIT_SET || op_reg == OP_IO_BIT_CLEAR)) begin
        io_we <= 1'b1;
        io_wdata <= io_rdata;
        io_wdata[bit_sel_reg] <= (op_reg == OP_IO_BIT_SET);
      end
    end
  end

  // One wait state: the answer is registered so prdata and pslverr come from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == DMBU_OFS_STATUS) begin
          prdata <= {29'h0000_0000, state_reg, instr_ready};
        end else if (paddr == DMBU_OFS_FLAGS) begin
          prdata <= {24'h00_0000, flags_reg};
        end else if (paddr == DMBU_OFS_STACK) begin
          prdata <= {24'h00_0000, sp_reg};
        end else if (apb_hit_rf && paddr[1:0] == 2'b00) begin
          prdata <= {24'h00_0000, rf_reg[paddr[6:2]]};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule

// File: design/dmbu_pkg.sv
package dmbu_pkg;

  localparam int DMBU_NREG = 32;
  localparam int DMBU_DISP_W = 6;

  // Low register of each pointer pair; the high byte sits one above.
  localparam logic [4:0] DMBU_X_LO = 5'h1A;
  localparam logic [4:0] DMBU_Y_LO = 5'h1C;
  localparam logic [4:0] DMBU_Z_LO = 5'h1E;
  localparam logic [4:0] DMBU_R0 = 5'h00;

  // Flag positions inside processor_flags_register.
  localparam int DMBU_FLAG_C = 0;
  localparam int DMBU_FLAG_Z = 1;
  localparam int DMBU_FLAG_N = 2;
  localparam int DMBU_FLAG_V = 3;
  localparam int DMBU_FLAG_S = 4;
  localparam int DMBU_FLAG_H = 5;
  localparam int DMBU_FLAG_T = 6;
  localparam int DMBU_FLAG_I = 7;

  localparam logic [7:0] DMBU_FLAGS_RST = 8'h00;
  localparam logic [7:0] DMBU_SP_RST = 8'h00;
  localparam logic [7:0] DMBU_STACK_PAGE = 8'h00;
  localparam logic [5:0] DMBU_IO_BIT_LIMIT = 6'h1F;

  // APB byte offsets.
  localparam logic [11:0] DMBU_OFS_STATUS = 12'h000;
  localparam logic [11:0] DMBU_OFS_FLAGS = 12'h004;
  localparam logic [11:0] DMBU_OFS_STACK = 12'h008;
  localparam logic [11:0] DMBU_OFS_REGFILE = 12'h080;
  localparam logic [11:0] DMBU_OFS_REGFILE_END = 12'h0FC;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_LOAD_IND = 4'h1,
    OP_STORE_IND = 4'h2,
    OP_LOAD_ABS = 4'h3,
    OP_STORE_ABS = 4'h4,
    OP_PM_FETCH = 4'h5,
    OP_STACK_PUSH = 4'h6,
    OP_STACK_POP = 4'h7,
    OP_IO_BIT_SET = 4'h8,
    OP_IO_BIT_CLEAR = 4'h9,
    OP_ROTATE_LEFT = 4'hA,
    OP_ROTATE_RIGHT = 4'hB,
    OP_FLAG_CAPTURE = 4'hC,
    OP_FLAG_DEPOSIT = 4'hD,
    OP_FLAG_RAISE = 4'hE,
    OP_FLAG_LOWER = 4'hF
  } dmbu_op_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } dmbu_ptr_t;

  typedef enum logic [1:0] {
    MODE_PLAIN = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_PRE_DEC = 2'h2,
    MODE_DISP = 2'h3
  } dmbu_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PM_ISSUE = 2'b01,
    ST_PM_WRITE = 2'b11,
    ST_MEM = 2'b10
  } dmbu_state_t;

endpackage

// File: verification/dmbu_exec_assertions.sv
`timescale 1ns/1ps
module dmbu_exec_checker
  import dmbu_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_valid,
  input wire dmbu_op_t instr_op,
  input wire logic [2:0] instr_bit,
  input wire logic [ADDR_W-1:0] instr_addr,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic io_re,
  input wire logic io_we,
  input wire logic [7:0] flags_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic take;
  logic ld_op;
  logic st_op;
  logic io_op;
  logic one_op;
  logic io_low;
  assign take = instr_valid && instr_ready;
  assign ld_op = instr_op inside {OP_LOAD_IND, OP_LOAD_ABS, OP_STACK_POP};
  assign st_op = instr_op inside {OP_STORE_IND, OP_STORE_ABS, OP_STACK_PUSH};
  assign io_op = instr_op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
  assign one_op = instr_op inside {OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_FLAG_CAPTURE,
    OP_FLAG_DEPOSIT, OP_FLAG_RAISE, OP_FLAG_LOWER};
  assign io_low = (instr_addr[5:0] <= DMBU_IO_BIT_LIMIT) && (instr_addr[ADDR_W-1:6] == '0);
  a_load_two_cycle: assert property (take && ld_op |=>
    mem_re && !instr_ready ##1 instr_done)
    else $error("load did not read then finish in two cycles");
  a_store_two_cycle: assert property (take && st_op |=>
    mem_we && !instr_ready ##1 instr_done)
    else $error("store did not write then finish in two cycles");
  a_io_bit_rmw: assert property (take && io_op && io_low |=>
    io_re && !io_we ##1 io_we && instr_done)
    else $error("I/O bit operation sequence wrong");
  a_io_high_skip: assert property (take && io_op && !io_low |=>
    instr_done && !io_re ##1 !io_we)
    else $error("I/O bit operation above limit touched the register");
  a_single_cycle_done: assert property (take && one_op |=> instr_done)
    else $error("single cycle operation did not finish");
  a_flag_raise_only: assert property (take && instr_op == OP_FLAG_RAISE |=>
    flags_out == ($past(flags_out) | (8'h01 << $past(instr_bit))))
    else $error("flag raise changed the wrong bits");
  a_flag_lower_only: assert property (take && instr_op == OP_FLAG_LOWER |=>
    flags_out == ($past(flags_out) & ~(8'h01 << $past(instr_bit))))
    else $error("flag lower changed the wrong bits");
  a_capture_t_only: assert property (take && instr_op == OP_FLAG_CAPTURE |=>
    (flags_out & 8'hBF) == ($past(flags_out) & 8'hBF))
    else $error("bit capture changed a flag other than T");
  a_transfer_flags_kept: assert property (take && (ld_op || st_op) |=>
    $stable(flags_out) [*2])
    else $error("data transfer changed the flags");
  a_deposit_flags_kept: assert property (take && instr_op == OP_FLAG_DEPOSIT |=>
    $stable(flags_out))
    else $error("bit deposit changed the flags");
  c_store: cover property (take && st_op);
  c_io_high: cover property (take && io_op && !io_low);
  c_rotate: cover property (take && instr_op == OP_ROTATE_LEFT);
endmodule

// File: verification/dmbu_far_side.sv
`timescale 1ns/1ps
module dmbu_far_side (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata,
  input wire logic [14:0] pm_addr,
  input wire logic pm_re,
  output logic [15:0] pm_rdata,
  input wire logic [5:0] io_addr,
  input wire logic io_re,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata
);
  logic [7:0] dmem [256];
  logic [7:0] iomem [64];
  logic [7:0] mem_last;
  logic [7:0] io_last;
  logic [15:0] pm_last;
  initial begin
    for (int i = 0; i < 256; i++) dmem[i] = 8'(i) ^ 8'hA5;
    for (int i = 0; i < 64; i++) iomem[i] = 8'(i) ^ 8'h3C;
    mem_last = 8'h00;
    io_last = 8'h00;
    pm_last = 16'h0000;
  end
  // Idle read lines show the inverse of the last value so stale data never matches.
  assign mem_rdata = mem_re ? dmem[mem_addr[7:0]] : ~mem_last;
  assign io_rdata = io_re ? iomem[io_addr] : ~io_last;
  assign pm_rdata = pm_re ? {~pm_addr[7:0], pm_addr[7:0]} : ~pm_last;
  always @(posedge clk) begin
    if (mem_we) dmem[mem_addr[7:0]] <= mem_wdata;
    if (io_we) iomem[io_addr] <= io_wdata;
    if (mem_re) mem_last <= mem_rdata;
    if (io_re) io_last <= io_rdata;
    if (pm_re) pm_last <= pm_rdata;
  end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dmbu_pkg::*;
  typedef struct {
    dmbu_op_t op; int rg; int bt; dmbu_ptr_t pt; dmbu_mode_t md;
    int dp; int ad; int k; int o; logic [7:0] ex;
  } dmbu_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, seen;
  logic [3:0] pstrb;
  logic instr_valid, instr_ready, instr_done, mem_we, mem_re, pm_re, io_re, io_we;
  dmbu_op_t instr_op;
  logic [4:0] instr_reg;
  logic [2:0] instr_bit;
  dmbu_ptr_t instr_ptr;
  dmbu_mode_t instr_mode;
  logic [5:0] instr_disp, io_addr;
  logic [15:0] instr_addr, mem_addr, pm_rdata;
  logic [7:0] mem_wdata, mem_rdata, io_wdata, io_rdata, flags_out, stack_ptr_out;
  logic [14:0] pm_addr;
  logic err_q;
  int bad_count = 0;
  int checked = 0;
  dmbu_row_t rows [26];
  dmbu_exec u_dmbu_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_reg(instr_reg), .instr_bit(instr_bit), .instr_ptr(instr_ptr),
    .instr_mode(instr_mode), .instr_disp(instr_disp), .instr_addr(instr_addr),
    .instr_ready(instr_ready), .instr_done(instr_done), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
    .pm_addr(pm_addr), .pm_re(pm_re), .pm_rdata(pm_rdata), .io_addr(io_addr),
    .io_re(io_re), .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .flags_out(flags_out), .stack_ptr_out(stack_ptr_out));
  dmbu_far_side u_dmbu_far_side (.clk(pclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata), .pm_addr(pm_addr),
    .pm_re(pm_re), .pm_rdata(pm_rdata), .io_addr(io_addr), .io_re(io_re), .io_we(io_we),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input dmbu_row_t r);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= r.op;
    instr_reg <= r.rg[4:0];
    instr_bit <= r.bt[2:0];
    instr_ptr <= r.pt;
    instr_mode <= r.md;
    instr_disp <= r.dp[5:0];
    instr_addr <= r.ad[15:0];
    do begin
      @(posedge pclk);
    end while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    do begin
      @(posedge pclk);
    end while (instr_done !== 1'b1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, instr_valid} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    {instr_reg, instr_bit, instr_disp, instr_addr} = 30'h0000_0000;
    instr_op = OP_NOP;
    instr_ptr = PTR_X;
    instr_mode = MODE_PLAIN;
    rows = '{
      '{OP_LOAD_IND, 1, 0, PTR_X, MODE_POST_INC, 0, 0, 0, 1, 8'hB5},
      '{OP_LOAD_IND, 2, 0, PTR_X, MODE_PLAIN, 0, 0, 0, 2, 8'hB4},
      '{OP_LOAD_IND, 3, 0, PTR_Y, MODE_PRE_DEC, 0, 0, 0, 3, 8'hBA},
      '{OP_LOAD_IND, 4, 0, PTR_Y, MODE_DISP, 5, 0, 0, 4, 8'h81},
      '{OP_STORE_IND, 5, 0, PTR_Y, MODE_POST_INC, 0, 0, 1, 8'h1F, 8'h3C},
      '{OP_STORE_IND, 4, 0, PTR_Y, MODE_PRE_DEC, 0, 0, 1, 8'h1F, 8'h81},
      '{OP_STORE_IND, 1, 0, PTR_Z, MODE_DISP, 3, 0, 1, 8'h33, 8'hB5},
      '{OP_LOAD_ABS, 6, 0, PTR_X, MODE_PLAIN, 0, 16'h0040, 0, 6, 8'hE5},
      '{OP_STORE_ABS, 6, 0, PTR_X, MODE_PLAIN, 0, 16'h0041, 1, 8'h41, 8'hE5},
      '{OP_STACK_PUSH, 3, 0, PTR_X, MODE_PLAIN, 0, 0, 1, 8'h00, 8'hBA},
      '{OP_STACK_POP, 7, 0, PTR_X, MODE_PLAIN, 0, 0, 0, 7, 8'hBA},
      '{OP_IO_BIT_SET, 0, 2, PTR_X, MODE_PLAIN, 0, 16'h0005, 2, 5, 8'h3D},
      '{OP_IO_BIT_CLEAR, 0, 5, PTR_X, MODE_PLAIN, 0, 16'h001F, 2, 8'h1F, 8'h03},
      '{OP_IO_BIT_SET, 0, 0, PTR_X, MODE_PLAIN, 0, 16'h0020, 2, 8'h20, 8'h1C},
      '{OP_FLAG_RAISE, 0, 3, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h08},
      '{OP_FLAG_RAISE, 0, 4, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h18},
      '{OP_FLAG_RAISE, 0, 5, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h38},
      '{OP_FLAG_LOWER, 0, 3, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h30},
      '{OP_FLAG_LOWER, 0, 4, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h20},
      '{OP_FLAG_LOWER, 0, 5, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h00},
      '{OP_ROTATE_LEFT, 6, 0, PTR_X, MODE_PLAIN, 0, 0, 0, 6, 8'hCA},
      '{OP_ROTATE_RIGHT, 6, 0, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h0C},
      '{OP_FLAG_CAPTURE, 6, 7, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h4C},
      '{OP_FLAG_DEPOSIT, 2, 0, PTR_X, MODE_PLAIN, 0, 0, 0, 2, 8'hB5},
      '{OP_ROTATE_LEFT, 0, 0, PTR_X, MODE_PLAIN, 0, 0, 3, 0, 8'h42},
      '{OP_PM_FETCH, 0, 0, PTR_Z, MODE_PLAIN, 0, 0, 0, 0, 8'h18}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("flags after reset", {24'h0, flags_out}, 32'h0);
    chk("stack after reset", {24'h0, stack_ptr_out}, 32'h0);
    apb(1'b1, 12'h0E8, 32'h10);
    apb(1'b1, 12'h0F0, 32'h20);
    apb(1'b1, 12'h0F8, 32'h30);
    apb(1'b1, 12'h094, 32'h3C);
    foreach (rows[i]) begin
      run(rows[i]);
      if (rows[i].k == 1) seen = 32'(u_dmbu_far_side.dmem[rows[i].o]);
      else if (rows[i].k == 2) begin
        // The I/O write lands one edge after the done pulse.
        @(posedge pclk);
        seen = 32'(u_dmbu_far_side.iomem[rows[i].o]);
      end
      else begin
        apb(1'b0, rows[i].k == 3 ? DMBU_OFS_FLAGS : DMBU_OFS_REGFILE + 12'(4 * rows[i].o), 0);
        seen = rd_q;
      end
      chk($sformatf("row %0d", i), seen, {24'h0, rows[i].ex});
    end
    apb(1'b0, 12'h0F8, 0);
    chk("Z low kept", rd_q, 32'h30);
    apb(1'b1, DMBU_OFS_STACK, 32'h5A);
    apb(1'b0, DMBU_OFS_STACK, 0);
    chk("stack read", rd_q, 32'h5A);
    pstrb <= 4'hE;
    apb(1'b1, DMBU_OFS_STACK, 32'h11);
    pstrb <= 4'hF;
    apb(1'b0, DMBU_OFS_STACK, 0);
    chk("stack strobe off", rd_q, 32'h5A);
    run('{OP_STACK_PUSH, 1, 0, PTR_X, MODE_PLAIN, 0, 0, 0, 0, 8'h00});
    chk("push data", 32'(u_dmbu_far_side.dmem[8'h5A]), 32'hB5);
    chk("push pointer", {24'h0, stack_ptr_out}, 32'h59);
    // Pre-decrement across the byte boundary must borrow into the high register.
    apb(1'b1, 12'h0EC, 32'h01);
    apb(1'b1, 12'h0E8, 32'h00);
    run('{OP_STORE_IND, 5, 0, PTR_X, MODE_PRE_DEC, 0, 0, 0, 0, 8'h00});
    chk("borrow store", 32'(u_dmbu_far_side.dmem[8'hFF]), 32'h3C);
    apb(1'b0, 12'h0EC, 0);
    chk("X high", rd_q, 32'h0);
    apb(1'b0, 12'h00C, 0);
    chk("unmapped error", {31'h0, err_q}, 32'h1);
    chk("unmapped data", rd_q, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("flags in reset", {24'h0, flags_out}, 32'h0);
    chk("ready in reset", {31'h0, instr_ready}, 32'h0);
    chk("stack in reset", {24'h0, stack_ptr_out}, 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("ready after reset", {31'h0, instr_ready}, 32'h1);
    run('{OP_LOAD_IND, 8, 0, PTR_X, MODE_POST_INC, 0, 0, 0, 0, 8'h00});
    apb(1'b0, 12'h0E8, 0);
    chk("X low after load", rd_q, 32'h1);
    apb(1'b0, 12'h0A0, 0);
    chk("load after reset", rd_q, 32'hBA);
    tally_and_finish();
  end
endmodule
bind dmbu_exec dmbu_exec_checker #(.ADDR_W(ADDR_W)) u_dmbu_exec_checker (
  .pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .instr_op(instr_op),
  .instr_bit(instr_bit), .instr_addr(instr_addr), .instr_ready(instr_ready),
  .instr_done(instr_done), .mem_we(mem_we), .mem_re(mem_re), .io_re(io_re),
  .io_we(io_we), .flags_out(flags_out));
